//--- hdl/spi_err_pkg.sv
/*
  Constants shared by the serial peripheral error and flag logic.
  Assumes a byte-wide shift engine on the link clock and a CPU-side
  register strobe interface on core_clk.
*/
// How it works
// - Master with slave-select input low is a mode fault.
// - Mode fault sets its flag; interrupt requested when enabled.
// - Mode fault clears the peripheral enable, releasing all outputs.
// - Mode fault clears master select, falling back to slave.
// - Mode fault flag clears by status read while set, then control write.
// - While faulted, enable and master bits cannot be set outside clearing.
// - Slave never sets mode fault, but keeps one already set.
// - Byte completing while done flag still set is an overrun.
// - Overrun sets its flag; interrupt requested when enabled.
// - After overrun the first unread byte stays; later bytes dropped.
// - Status read clears the overrun flag.
// - Data write during a transfer is discarded; transfer unaffected.
// - Write collisions are detected in master and slave operation.
// - Write collision sets its flag and never requests an interrupt.
// - Received bytes land in a core-clock buffer, reads never collide.
package spi_err_pkg;
  localparam int BYTE_W = 8;
  localparam int BIT_CNT_W = 3;
  // Reset values of control bits and data bytes
  localparam logic PEN_RST = 1'b0;
  localparam logic MSEL_RST = 1'b0;
  localparam logic IRQ_EN_RST = 1'b0;
  localparam logic [7:0] DATA_RST = 8'h00;
  // Status vector field positions
  localparam int ST_DONE = 0;
  localparam int ST_COLL = 1;
  localparam int ST_OVERRUN = 2;
  localparam int ST_FAULT = 3;
  localparam int ST_W = 4;
  // Last bit index of a byte on the link
  localparam logic [2:0] LAST_BIT = 3'h7;
endpackage : spi_err_pkg

//--- hdl/sync2.sv
/*
  Two-flop level synchroniser into the clock given on clk.
  Assumes the input is a level held long against the destination period.
*/
`timescale 1ns/100ps
module sync2 #(
  parameter int W = 1
) (
  input wire logic clk, // Destination clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic [W-1:0] d, // Asynchronous level
  output logic [W-1:0] q // Synchronised level
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // sync2

//--- hdl/spi_link_shift.sv
/*
  Link-side byte shifter, clocked by the serial clock.
  Assumes tx_byte is held steady while a transfer is in progress, and
  that rx_byte is read only after done_tgl has crossed to the core.
*/
`timescale 1ns/100ps
module spi_link_shift (
  input wire logic link_sck, // Serial clock
  input wire logic link_rst, // Reset already synchronised to link_sck
  input wire logic en, // Peripheral enable, synchronised to link_sck
  input wire logic sdi, // Serial data in
  input wire logic [7:0] tx_byte, // Byte to send, quasi-static
  output logic sdo, // Serial data out
  output logic busy, // Transfer in progress (registered)
  output logic done_tgl, // Toggles once per completed byte
  output logic [7:0] rx_byte // Last completed byte
);
  logic [2:0] cnt_r;
  logic [7:0] sh_r;

  assign sdo = (cnt_r == 3'h0) ? tx_byte[7] : sh_r[7];

  always_ff @(posedge link_sck) begin
    if (link_rst || !en) begin
      cnt_r <= 3'h0;
      sh_r <= spi_err_pkg::DATA_RST;
      busy <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 3'h1;
      sh_r <= (cnt_r == 3'h0) ? {tx_byte[6:0], sdi} : {sh_r[6:0], sdi};
      busy <= (cnt_r != spi_err_pkg::LAST_BIT);
    end
  end

  // Completed byte held until the next one ends
  always_ff @(posedge link_sck) begin
    if (link_rst) begin
      done_tgl <= 1'b0;
      rx_byte <= spi_err_pkg::DATA_RST;
    end else if (en && cnt_r == spi_err_pkg::LAST_BIT) begin
      done_tgl <= ~done_tgl;
      rx_byte <= {sh_r[6:0], sdi};
    end
  end
endmodule // spi_link_shift

//--- hdl/spi_err_flags.sv
/*
  Error detection and flag handling of the byte-wide serial peripheral:
  mode fault, overrun, write collision, interrupt request and the
  software clearing sequences. Register accesses arrive as one-cycle
  strobes on core_clk; the shifter runs on link_sck.
*/
`timescale 1ns/100ps
module spi_err_flags (
  input wire logic core_clk, // CPU clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic link_sck, // Serial clock from the link
  input wire logic ss_n, // Slave-select pin, active low, asynchronous
  input wire logic sdi, // Serial data pin in, asynchronous
  output logic sdo, // Serial data pin out
  output logic sdo_oe, // High while the device drives sdo
  input wire logic csr_rd, // Pulse: control/status register read
  input wire logic cr_wr, // Pulse: control register write
  input wire logic cr_pen, // Write data: peripheral enable
  input wire logic cr_msel, // Write data: master select
  input wire logic cr_irq_en, // Write data: interrupt enable
  input wire logic dr_rd, // Pulse: data register read
  input wire logic dr_wr, // Pulse: data register write
  input wire logic [7:0] dr_wdata, // Data register write value
  output logic [7:0] dr_rdata, // Receive buffer (registered)
  output logic peripheral_enable_bit, // Control bit (registered)
  output logic master_select_bit, // Control bit (registered)
  output logic transfer_irq_enable, // Control bit (registered)
  output logic [3:0] status, // Flags: done, collision, overrun, fault
  output logic irq // Interrupt request, level
);
  logic pen_r;
  logic msel_r;
  logic irq_en_r;
  logic done_r;
  logic overrun_r;
  logic coll_r;
  logic fault_r;
  logic fault_arm_r;
  logic done_arm_r;
  logic coll_arm_r;
  logic [7:0] tx_data_r;
  logic [7:0] rx_buf_r;
  logic done_d_r;
  logic ss_act_s;
  logic busy_s;
  logic done_s;
  logic link_rst;
  logic pen_l;
  logic busy_l;
  logic done_tgl_l;
  logic [7:0] rx_byte_l;
  logic fault;
  logic byte_evt;
  logic coll;
  logic fault_clr;
  logic dr_acc;

  // Select is synchronised as active-high so its reset value is the idle level
  sync2 #(.W(3)) u_core_sync (
    .clk(core_clk),
    .rst(reset),
    .d({~ss_n, busy_l, done_tgl_l}),
    .q({ss_act_s, busy_s, done_s})
  );

  sync2 #(.W(2)) u_link_sync (
    .clk(link_sck),
    .rst(1'b0),
    .d({reset, pen_r}),
    .q({link_rst, pen_l})
  );

  spi_link_shift u_shift (
    .link_sck(link_sck),
    .link_rst(link_rst),
    .en(pen_l),
    .sdi(sdi),
    .tx_byte(tx_data_r),
    .sdo(sdo),
    .busy(busy_l),
    .done_tgl(done_tgl_l),
    .rx_byte(rx_byte_l)
  );

  assign fault = msel_r && ss_act_s;
  assign byte_evt = done_s ^ done_d_r;
  assign coll = dr_wr && busy_s;
  assign dr_acc = dr_rd || dr_wr;
  assign fault_clr = cr_wr && fault_arm_r;
  assign sdo_oe = pen_r && (msel_r || ss_act_s);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      done_d_r <= 1'b0;
    end else begin
      done_d_r <= done_s;
    end
  end

  // Control bits
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pen_r <= spi_err_pkg::PEN_RST;
      msel_r <= spi_err_pkg::MSEL_RST;
      irq_en_r <= spi_err_pkg::IRQ_EN_RST;
    end else begin
      if (cr_wr) begin
        irq_en_r <= cr_irq_en;
      end
      if (fault) begin
        pen_r <= 1'b0;
        msel_r <= 1'b0;
      end else if (cr_wr && (!fault_r || fault_arm_r)) begin
        pen_r <= cr_pen;
        msel_r <= cr_msel;
      end else if (cr_wr) begin
        pen_r <= pen_r && cr_pen;
        msel_r <= msel_r && cr_msel;
      end
    end
  end

  // Mode fault flag and its clearing sequence
  always_ff @(posedge core_clk) begin
    if (reset) begin
      fault_r <= 1'b0;
      fault_arm_r <= 1'b0;
    end else begin
      // set only as master, set wins
      if (fault) begin
        fault_r <= 1'b1;
      end else if (fault_clr) begin
        fault_r <= 1'b0;
      end
      // read while set arms the clear
      if (csr_rd && fault_r) begin
        fault_arm_r <= 1'b1;
      end else if (cr_wr) begin
        fault_arm_r <= 1'b0;
      end
    end
  end

  // Transfer done, overrun and receive buffer
  always_ff @(posedge core_clk) begin
    if (reset) begin
      done_r <= 1'b0;
      done_arm_r <= 1'b0;
      overrun_r <= 1'b0;
      rx_buf_r <= spi_err_pkg::DATA_RST;
    end else begin
      if (byte_evt && !done_r) begin
        done_r <= 1'b1;
        rx_buf_r <= rx_byte_l;
      end else if (done_arm_r && dr_acc) begin
        done_r <= 1'b0;
      end
      if (csr_rd && done_r) begin
        done_arm_r <= 1'b1;
      end else if (dr_acc) begin
        done_arm_r <= 1'b0;
      end
      if (byte_evt && done_r) begin
        overrun_r <= 1'b1;
      end else if (csr_rd) begin
        overrun_r <= 1'b0;
      end
    end
  end

  // Write collision and transmit data
  always_ff @(posedge core_clk) begin
    if (reset) begin
      coll_r <= 1'b0;
      coll_arm_r <= 1'b0;
      tx_data_r <= spi_err_pkg::DATA_RST;
    end else begin
      if (dr_wr && !busy_s) begin
        tx_data_r <= dr_wdata;
      end
      if (coll) begin
        coll_r <= 1'b1;
      end else if (coll_arm_r && dr_acc) begin
        coll_r <= 1'b0;
      end
      if (csr_rd && coll_r) begin
        coll_arm_r <= 1'b1;
      end else if (dr_acc) begin
        coll_arm_r <= 1'b0;
      end
    end
  end

  assign dr_rdata = rx_buf_r;
  assign peripheral_enable_bit = pen_r;
  assign master_select_bit = msel_r;
  assign transfer_irq_enable = irq_en_r;
  assign status[spi_err_pkg::ST_DONE] = done_r;
  assign status[spi_err_pkg::ST_COLL] = coll_r;
  assign status[spi_err_pkg::ST_OVERRUN] = overrun_r;
  assign status[spi_err_pkg::ST_FAULT] = fault_r;
  assign irq = irq_en_r && (done_r || overrun_r || fault_r);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  property p_fault_flag;
    msel_r && ss_act_s |=> fault_r;
  endproperty
  a_fault_flag: assert property (p_fault_flag)
    else $error("mode fault not flagged");

  property p_fault_irq;
    msel_r && ss_act_s && irq_en_r && !cr_wr |=> irq;
  endproperty
  a_fault_irq: assert property (p_fault_irq)
    else $error("mode fault without interrupt");

  property p_fault_spe;
    msel_r && ss_act_s |=> !pen_r ##0 !sdo_oe;
  endproperty
  a_fault_spe: assert property (p_fault_spe)
    else $error("enable kept after mode fault");

  property p_fault_master_select_bit;
    msel_r && ss_act_s |=> !msel_r;
  endproperty
  a_fault_master_select_bit: assert property (p_fault_master_select_bit)
    else $error("master kept after mode fault");

  property p_mode_fault_flag_clear;
    fault_r ##1 !fault_r |-> $past(cr_wr) && $past(fault_arm_r);
  endproperty
  a_mode_fault_flag_clear: assert property (p_mode_fault_flag_clear)
    else $error("mode fault cleared out of sequence");

  property p_locked;
    fault_r && !fault_arm_r && !pen_r && !msel_r |=> !pen_r && !msel_r;
  endproperty
  a_locked: assert property (p_locked)
    else $error("enable or master set while faulted");

  property p_slave_quiet;
    !msel_r && !fault_r |=> !fault_r;
  endproperty
  a_slave_quiet: assert property (p_slave_quiet)
    else $error("mode fault set in slave");

  property p_overrun;
    byte_evt && done_r |=> overrun_r && $stable(rx_buf_r);
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun missed or buffer overwritten");

  property p_ovr_clear;
    csr_rd && !(byte_evt && done_r) |=> !overrun_r;
  endproperty
  a_ovr_clear: assert property (p_ovr_clear)
    else $error("overrun not cleared by status read");

  property p_collide;
    dr_wr && busy_s |=> coll_r && $stable(tx_data_r);
  endproperty
  a_collide: assert property (p_collide)
    else $error("collision write not discarded");

  property p_write_collision_flag_no_irq;
    coll_r && !done_r && !overrun_r && !fault_r |-> !irq;
  endproperty
  a_write_collision_flag_no_irq: assert property (p_write_collision_flag_no_irq)
    else $error("collision raised interrupt");

  property p_rx_load;
    byte_evt && !done_r |=> done_r && rx_buf_r == $past(rx_byte_l);
  endproperty
  a_rx_load: assert property (p_rx_load)
    else $error("received byte not buffered");

  property p_write_collision_flag_clear;
    csr_rd && coll_r && !coll ##1 (dr_rd && !dr_wr) |=> !coll_r;
  endproperty
  a_write_collision_flag_clear: assert property (p_write_collision_flag_clear)
    else $error("collision flag not cleared");
endmodule // spi_err_flags

//--- sim/spi_far_end.sv
/*
  Far-end serial master model: repeats one byte pattern MSB first.
  Assumes a free-running link clock; the bench picks pattern and select.
*/
`timescale 1ns/100ps
module spi_far_end (
  input wire logic link_sck, // Serial clock
  input wire logic [7:0] tx_byte, // Pattern sent over and over
  input wire logic sel_req, // High to pull slave-select low
  output logic sdi, // Serial data to the device
  output logic ss_n // Slave-select, active low
);
  logic [2:0] bit_r = 3'h7;
  // Data moves on the falling edge, clear of the sampling edge
  always @(negedge link_sck) begin
    bit_r <= bit_r - 3'h1;
  end
  assign sdi = tx_byte[bit_r];
  assign ss_n = ~sel_req;
endmodule // spi_far_end

//--- sim/tb.sv
/*
  Self-checking bench for the serial error and flag logic.
  Assumes the far-end model in spi_far_end and a free link clock.
*/
`timescale 1ns/100ps
module tb;
  logic core_clk, reset, link_sck, csr_rd, cr_wr, cr_pen, cr_msel, cr_irq_en;
  logic dr_rd, dr_wr, sel_req;
  logic [7:0] dr_wdata, pat;
  logic sdi, ss_n, sdo, sdo_oe, pe, ms, ie, irq;
  logic [7:0] dr_rdata;
  logic [3:0] status;
  int error_cnt = 0;
  int check_count = 0;
  int n;
  // Rows: {spe, master_select_bit, transfer_irq_enable} written, then {pe, ms, ie, sdo_oe} expected
  logic [6:0] rows [5] = '{7'h00, 7'h5A, 7'h36, 7'h7F, 7'h6D};

  spi_far_end far (.link_sck(link_sck), .tx_byte(pat), .sel_req(sel_req), .sdi(sdi),
    .ss_n(ss_n));
  spi_err_flags dut (.core_clk(core_clk), .reset(reset), .link_sck(link_sck), .ss_n(ss_n),
    .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .csr_rd(csr_rd), .cr_wr(cr_wr), .cr_pen(cr_pen),
    .cr_msel(cr_msel), .cr_irq_en(cr_irq_en), .dr_rd(dr_rd), .dr_wr(dr_wr),
    .dr_wdata(dr_wdata), .dr_rdata(dr_rdata), .peripheral_enable_bit(pe),
    .master_select_bit(ms), .transfer_irq_enable(ie), .status(status), .irq(irq));

  task automatic tick(int k = 1);
    repeat (k) @(posedge core_clk);
    #2;
  endtask
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cw(logic [2:0] v);
    {cr_pen, cr_msel, cr_irq_en} = v;
    cr_wr = 1'b1;
    tick();
    cr_wr = 1'b0;
    tick();
  endtask
  task automatic csr();
    csr_rd = 1'b1;
    tick();
    csr_rd = 1'b0;
    tick();
  endtask
  task automatic drd();
    dr_rd = 1'b1;
    tick();
    dr_rd = 1'b0;
    tick();
  endtask
  task automatic dwr(logic [7:0] d);
    dr_wdata = d;
    dr_wr = 1'b1;
    tick();
    dr_wr = 1'b0;
    tick();
  endtask
  task automatic wait_bit(int b);
    n = 0;
    while (status[b] !== 1'b1 && n < 400) begin
      tick();
      n++;
    end
    chk("flag wait", 8'h01, {7'h00, n < 400});
  endtask
  task automatic give_verdict();
    if (error_cnt == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    link_sck = 1'b0;
    #7;
    forever #24 link_sck = ~link_sck;
  end
  initial begin
    #200000;
    error_cnt++;
    give_verdict();
  end

  initial begin
    reset = 1'b1;
    {csr_rd, cr_wr, cr_pen, cr_msel, cr_irq_en, dr_rd, dr_wr, sel_req} = 8'h00;
    dr_wdata = 8'h00;
    pat = 8'h00;
    tick(20);
    reset = 1'b0;
    chk("status", 8'h00, {4'h0, status});
    chk("ctrl", 8'h00, {4'h0, pe, ms, ie, sdo_oe});
    chk("rdata", 8'h00, dr_rdata);
    chk("irq", 8'h00, {7'h00, irq});
    foreach (rows[i]) begin
      cw(rows[i][6:4]);
      chk("ctrl", {4'h0, rows[i][3:0]}, {4'h0, pe, ms, ie, sdo_oe});
    end
    cw(3'h0);
    tick(10);
    csr();
    drd();
    pat = 8'hFF;
    cw(3'h5);
    wait_bit(0);
    chk("rdata", 8'hFF, dr_rdata);
    pat = 8'h00;
    wait_bit(2);
    chk("rdata kept", 8'hFF, dr_rdata);
    chk("irq", 8'h01, {7'h00, irq});
    cw(3'h0);
    tick(10);
    csr();
    chk("overrun", 8'h00, {7'h00, status[2]});
    for (int m = 0; m < 2; m++) begin
      cw({1'b1, m[0], 1'b1});
      wait_bit(0);
      csr();
      drd();
      // Fresh byte just done: write lands mid-transfer
      wait_bit(0);
      tick(3);
      dwr(8'hA5);
      chk("collision", 8'h01, {7'h00, status[1]});
      chk("irq", {7'h00, status[0] | status[2] | status[3]}, {7'h00, irq});
      csr();
      drd();
      chk("collision", 8'h00, {7'h00, status[1]});
    end
    cw(3'h0);
    tick(10);
    csr();
    drd();
    dwr(8'hA5);
    chk("idle write", 8'h00, {7'h00, status[1]});
    chk("sdo", 8'h01, {7'h00, sdo});
    sel_req = 1'b1;
    tick(10);
    chk("fault", 8'h00, {7'h00, status[3]});
    sel_req = 1'b0;
    cw(3'h7);
    sel_req = 1'b1;
    wait_bit(3);
    chk("ctrl", 8'h00, {5'h00, pe, ms, sdo_oe});
    chk("irq", 8'h01, {7'h00, irq});
    sel_req = 1'b0;
    tick(4);
    cw(3'h7);
    chk("ctrl", 8'h08, {4'h0, status[3], 1'b0, pe, ms});
    csr();
    cw(3'h7);
    chk("ctrl", 8'h03, {4'h0, status[3], 1'b0, pe, ms});
    give_verdict();
  end
endmodule // tb
